/* hw/driver_diag_pkg.sv */
/*
  Constants, register map and carrier types for the diagnostic status
  and fine PWM register block of a multi-output load driver.
  Assumes a single 10 MHz core clock.
*/
package driver_diag_pkg;
  // clock and time base
  localparam int CLK_HZ     = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // register offsets and reset value
  localparam logic [7:0]  ADDR_ULD_STS   = 8'h11;
  localparam logic [7:0]  ADDR_FAULT_STS = 8'h12;
  localparam logic [7:0]  ADDR_OUT5_PWM  = 8'h13;
  localparam logic [15:0] REG_RESET      = 16'h0000;

  // output-five PWM register fields
  localparam int FSEL_BIT  = 15;
  localparam int DUTY_W    = 10;
  localparam int DUTY_STEPS = 1 << DUTY_W;

  // stage indices: 0..7 first four half-bridges, 8..12 high-sides 5..9
  localparam int N_STAGES = 13;
  localparam int N_HB     = 8;
  localparam int N_OC     = 5;
  localparam int IDX_HS1  = 0;
  localparam int IDX_LS1  = 1;
  localparam int IDX_OUT5 = 8;

  // timing: least times round up, the pwm step rounds down
  localparam int ULD_FILTER_US    = 100;
  localparam int ULD_FILTER_CYC   = ULD_FILTER_US * CYC_PER_US;
  localparam int EC_SETTLE_US     = 32;
  localparam int EC_SETTLE_CYC    = EC_SETTLE_US * CYC_PER_US;
  localparam int OC_RETRY_UNIT_US = 1000;
  localparam int OC_RETRY_UNIT_CYC = OC_RETRY_UNIT_US * CYC_PER_US;
  localparam int PWM_F_LO_HZ      = 170;
  localparam int PWM_F_HI_HZ      = 225;
  localparam int PWM_STEP_LO      = CLK_HZ / (PWM_F_LO_HZ * DUTY_STEPS);
  localparam int PWM_STEP_HI      = CLK_HZ / (PWM_F_HI_HZ * DUTY_STEPS);

  // serial-link register request, one cycle per access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // load and supply sense from the analog side
  typedef struct packed {
    logic [N_STAGES-1:0] on_req;
    logic [N_STAGES-1:0] under;
    logic [N_OC-1:0]     oc;
    logic                uv;
    logic                ov;
    logic                ec_below;
    logic                ec_above;
  } sense_t;

  // configuration and control bits held elsewhere
  typedef struct packed {
    logic       mask_underload_high1;
    logic       mask_underload_low1;
    logic       mask_underload_all;
    logic       supply_fault_latch_mode;
    logic       oc_recovery_en;
    logic [1:0] overcurrent_retry_delay;
    logic       internal_pwm_select;
    logic       fine_duty_enable;
    logic       ec_mode;
  } cfg_t;
endpackage

/* hw/driver_diag_status_regs.sv */
/*
  Diagnostic status registers (underload, overcurrent, supply, EC
  comparator) and the output-five fine PWM register with its generator.
  Assumes register accesses arrive as one-cycle strobes from the serial
  link decoder and all sense inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
module driver_diag_status_regs #(
  parameter int OC_RETRY_UNIT_CYC = driver_diag_pkg::OC_RETRY_UNIT_CYC,
  parameter int ULD_FILTER_CYC    = driver_diag_pkg::ULD_FILTER_CYC,
  parameter int EC_SETTLE_CYC     = driver_diag_pkg::EC_SETTLE_CYC
) (
  input  wire logic                       clk_i,              // core clock
  input  wire logic                       reset_i,            // async reset
  input  wire driver_diag_pkg::reg_req_t  req_i,              // register access
  input  wire driver_diag_pkg::sense_t    sense_i,            // load/supply sense
  input  wire driver_diag_pkg::cfg_t      cfg_i,              // control bits
  output logic [15:0]                     reg_rdata_o,        // read data
  output logic [12:0]                     stage_en_o,         // stage drive enables
  output logic                            global_underload_o, // global underload
  output logic                            global_supply_or_overcurrent_o, // global fault
  output logic                            out5_pwm_o          // output five pwm
);
  localparam int NS  = driver_diag_pkg::N_STAGES;
  localparam int NO  = driver_diag_pkg::N_OC;
  localparam int ULW = $clog2(ULD_FILTER_CYC + 1);
  localparam int ECW = $clog2(EC_SETTLE_CYC + 1);
  localparam int RTW = $clog2(4 * OC_RETRY_UNIT_CYC + 1);
  localparam int PSW = $clog2(driver_diag_pkg::PWM_STEP_LO + 1);
  localparam int DW  = driver_diag_pkg::DUTY_W;

  logic [NS-1:0] uld_flag_q;
  logic [NS-1:0] uld_flag_d;
  logic [NS-1:0] uld_evt;
  logic [NO-1:0] oc_flag_q;
  logic [NO-1:0] oc_flag_d;
  logic [NO-1:0] oc_evt;
  logic [NO-1:0] oc_off_q;
  logic [NO-1:0] oc_off_d;
  logic [NO-1:0] retry_done;
  logic          uv_flag_q;
  logic          uv_flag_d;
  logic          ov_flag_q;
  logic          ov_flag_d;
  logic [NS-1:0] stage_en_d;
  logic          supply_block;
  logic          rd_uld;
  logic          rd_fault;
  logic          wr_pwm;
  logic [NS-1:0] uld_clr;
  logic [NS-1:0] uld_mask;
  logic          global_uld_d;
  logic          global_soc_d;
  logic [15:0]   sts1_word;
  logic [15:0]   sts2_word;
  logic [15:0]   pwm_word;
  logic [15:0]   rdata_d;
  logic [1:0]    ec_cand;
  logic [1:0]    ec_shown_q;
  logic [ECW-1:0] ec_cnt_q;
  logic          ec_settled;
  logic          fsel_q;
  logic [DW-1:0] duty_q;
  logic          pwm_active;
  logic [PSW-1:0] pre_q;
  logic [PSW-1:0] pre_lim;
  logic          pre_tick;
  logic [DW-1:0] pwm_cnt_q;
  logic          out5_pwm_d;
  logic [RTW-1:0] retry_lim;

  //////////////////////////////////////////////////////////////////////
  // register decode: reads are one-cycle strobes, clears ride on them
  assign rd_uld   = req_i.rd && (req_i.addr == driver_diag_pkg::ADDR_ULD_STS);
  assign rd_fault = req_i.rd && (req_i.addr == driver_diag_pkg::ADDR_FAULT_STS);
  assign wr_pwm   = req_i.wr && (req_i.addr == driver_diag_pkg::ADDR_OUT5_PWM);
  assign uld_clr  = {{NO{rd_fault}}, {driver_diag_pkg::N_HB{rd_uld}}};

  //////////////////////////////////////////////////////////////////////
  // underload filter per stage; counter saturates, so a standing
  // underload keeps re-detecting and re-sets a flag cleared by a read
  for (genvar g = 0; g < NS; g++) begin : g_uld
    logic [ULW-1:0] cnt_q;
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        cnt_q <= '0;
      end else if (!(stage_en_o[g] && sense_i.under[g])) begin
        cnt_q <= '0; // only judged in on-mode
      end else if (cnt_q != ULW'(ULD_FILTER_CYC)) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign uld_evt[g] = (cnt_q == ULW'(ULD_FILTER_CYC));
  end

  // set beats clear when a detection meets the read
  assign uld_flag_d = (uld_flag_q & ~uld_clr) | uld_evt;

  //////////////////////////////////////////////////////////////////////
  // overcurrent on high-sides five to nine with optional retry
  assign retry_lim = RTW'((int'(cfg_i.overcurrent_retry_delay) + 1)
                          * OC_RETRY_UNIT_CYC - 1);

  for (genvar j = 0; j < NO; j++) begin : g_oc
    logic [RTW-1:0] rt_q;
    assign oc_evt[j] = sense_i.oc[j] && stage_en_o[driver_diag_pkg::IDX_OUT5 + j];
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        rt_q <= '0;
      end else if (!(oc_off_q[j] && cfg_i.oc_recovery_en) || retry_done[j]) begin
        rt_q <= '0;
      end else begin
        rt_q <= rt_q + 1'b1;
      end
    end
    assign retry_done[j] = oc_off_q[j] && cfg_i.oc_recovery_en
                           && (rt_q == retry_lim);
    // off until retry expires, or, without retry, until the flag is read away
    assign oc_off_d[j] = oc_evt[j]
                         || (oc_off_q[j] && !retry_done[j]
                             && (cfg_i.oc_recovery_en || oc_flag_q[j]));
  end

  assign oc_flag_d = (oc_flag_q & ~{NO{rd_fault}}) | oc_evt;

  //////////////////////////////////////////////////////////////////////
  // supply faults: raw level blocks at once; latch mode also waits
  // for the host to read the flag away
  assign uv_flag_d = (uv_flag_q && !rd_fault) || sense_i.uv;
  assign ov_flag_d = (ov_flag_q && !rd_fault) || sense_i.ov;
  assign supply_block = sense_i.uv || sense_i.ov
                        || (cfg_i.supply_fault_latch_mode
                            && (uv_flag_q || ov_flag_q));

  // uses next-state trip so the stage drops in the same edge as the flag
  assign stage_en_d = sense_i.on_req & ~{NS{supply_block}}
                      & ~{oc_off_d, {driver_diag_pkg::N_HB{1'b0}}};

  //////////////////////////////////////////////////////////////////////
  // global flags; comparator bits deliberately left out
  always_comb begin
    uld_mask = '0;
    uld_mask[driver_diag_pkg::IDX_HS1] = cfg_i.mask_underload_high1;
    uld_mask[driver_diag_pkg::IDX_LS1] = cfg_i.mask_underload_low1;
    if (cfg_i.mask_underload_all) begin
      uld_mask = '1;
    end
  end
  assign global_uld_d = |(uld_flag_d & ~uld_mask);
  assign global_soc_d = (|oc_flag_d) || uv_flag_d || ov_flag_d;

  //////////////////////////////////////////////////////////////////////
  // electrochromic comparators: debounced, never latched
  assign ec_cand = !cfg_i.ec_mode ? 2'h0 :
                   (sense_i.ec_below && !sense_i.ec_above) ? 2'h2 :
                   (sense_i.ec_above && !sense_i.ec_below) ? 2'h1 : 2'h0;
  assign ec_settled = (ec_cnt_q == ECW'(EC_SETTLE_CYC - 1));

  // counter restarts when the input equals the shown bits or they update, so bits hold 32 us at least
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ec_shown_q <= 2'h0;
      ec_cnt_q   <= '0;
    end else if (!cfg_i.ec_mode) begin
      ec_shown_q <= 2'h0;
      ec_cnt_q   <= '0;
    end else if (ec_cand == ec_shown_q) begin
      ec_cnt_q <= '0;
    end else if (ec_settled) begin
      ec_shown_q <= ec_cand;
      ec_cnt_q   <= '0;
    end else begin
      ec_cnt_q <= ec_cnt_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read words; unused positions are constant zero
  assign sts1_word = {uld_flag_q[0], uld_flag_q[1], uld_flag_q[2], uld_flag_q[3],
                      uld_flag_q[4], uld_flag_q[5], 4'h0,
                      uld_flag_q[6], uld_flag_q[7], 4'h0};
  assign sts2_word = {oc_flag_q[0], uld_flag_q[8], oc_flag_q[1], uld_flag_q[9],
                      oc_flag_q[2], uld_flag_q[10], oc_flag_q[3], uld_flag_q[11],
                      oc_flag_q[4], uld_flag_q[12], 2'h0,
                      uv_flag_q, ov_flag_q, ec_shown_q};
  assign pwm_word  = {fsel_q, 5'h00, duty_q};
  assign rdata_d   = rd_uld   ? sts1_word :
                     rd_fault ? sts2_word :
                     (req_i.rd && req_i.addr == driver_diag_pkg::ADDR_OUT5_PWM) ?
                     pwm_word : driver_diag_pkg::REG_RESET;

  //////////////////////////////////////////////////////////////////////
  // flag, enable and read-data state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      uld_flag_q  <= '0;
      oc_flag_q   <= '0;
      oc_off_q    <= '0;
      uv_flag_q   <= 1'b0;
      ov_flag_q   <= 1'b0;
      stage_en_o  <= '0;
      reg_rdata_o <= driver_diag_pkg::REG_RESET;
      global_underload_o             <= 1'b0;
      global_supply_or_overcurrent_o <= 1'b0;
    end else begin
      uld_flag_q  <= uld_flag_d;
      oc_flag_q   <= oc_flag_d;
      oc_off_q    <= oc_off_d;
      uv_flag_q   <= uv_flag_d;
      ov_flag_q   <= ov_flag_d;
      stage_en_o  <= stage_en_d;
      global_underload_o             <= global_uld_d;
      global_supply_or_overcurrent_o <= global_soc_d;
      if (req_i.rd) begin
        reg_rdata_o <= rdata_d; // unmapped reads return zero
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output-five pwm register: only defined fields are stored
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fsel_q <= 1'b0;
      duty_q <= '0;
    end else if (wr_pwm) begin
      fsel_q <= req_i.wdata[driver_diag_pkg::FSEL_BIT];
      duty_q <= req_i.wdata[DW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pwm generator: 1024 steps per period, step length sets frequency
  assign pwm_active = cfg_i.internal_pwm_select && cfg_i.fine_duty_enable;
  assign pre_lim    = fsel_q ? PSW'(driver_diag_pkg::PWM_STEP_HI - 1)
                             : PSW'(driver_diag_pkg::PWM_STEP_LO - 1);
  assign pre_tick   = (pre_q >= pre_lim);
  // compare with <= gives (duty + 1) high steps of 1024
  assign out5_pwm_d = pwm_active && stage_en_d[driver_diag_pkg::IDX_OUT5]
                      && (pwm_cnt_q <= duty_q);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_q      <= '0;
      pwm_cnt_q  <= '0;
      out5_pwm_o <= 1'b0;
    end else begin
      out5_pwm_o <= out5_pwm_d;
      if (!pwm_active) begin
        pre_q     <= '0; // field ignored, generator parked
        pwm_cnt_q <= '0;
      end else if (pre_tick) begin
        pre_q     <= '0;
        pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_ULD_GLOBAL: assert property (
    (|uld_flag_q[12:2] && !$past(cfg_i.mask_underload_all)) |-> global_underload_o)
    else $error("unmasked underload did not raise global flag");

  AST_ULD_MASK_HS1: assert property (
    ($past(cfg_i.mask_underload_high1) && uld_flag_q == 13'h0001)
    |-> !global_underload_o)
    else $error("masked first high-side underload reached global flag");

  AST_ULD_MASK_ALL: assert property (
    $past(cfg_i.mask_underload_all) |-> !global_underload_o)
    else $error("general mask failed to block global underload");

  AST_OC_TRIP: assert property (
    (oc_evt != '0) |=> ((oc_flag_q & $past(oc_evt)) == $past(oc_evt)
                        && (stage_en_o[12:8] & $past(oc_evt)) == '0
                        && global_supply_or_overcurrent_o))
    else $error("overcurrent did not flag and switch off its output");

  AST_UV_OFF: assert property (
    sense_i.uv |=> (stage_en_o == 13'h0000 && uv_flag_q))
    else $error("undervoltage left a stage on or flag clear");

  AST_OV_OFF: assert property (
    sense_i.ov |=> (stage_en_o == 13'h0000 && ov_flag_q))
    else $error("overvoltage left a stage on or flag clear");

  AST_SUPPLY_AUTO: assert property (
    (sense_i.on_req[0] && !sense_i.uv && !sense_i.ov
     && !cfg_i.supply_fault_latch_mode) |=> stage_en_o[0])
    else $error("stage not re-enabled after supply recovered");

  AST_EC_HOLD: assert property (
    ($changed(ec_shown_q) && cfg_i.ec_mode) |=> $stable(ec_shown_q) [*8])
    else $error("comparator bits changed too soon");

  AST_READ_CLEAR: assert property (
    (rd_uld && uld_evt[7:0] == 8'h00) |=> uld_flag_q[7:0] == 8'h00)
    else $error("status read did not clear underload flags");

  AST_PWM_IGNORED: assert property (
    !pwm_active |=> !out5_pwm_o)
    else $error("fine pwm active without both enables");

  AST_ULD_SET: assert property (
    (uld_evt != '0) |=> ((uld_flag_q & $past(uld_evt)) == $past(uld_evt)))
    else $error("underload detection did not set its flag");

  AST_OC_RETRY: assert property (
    (retry_done != '0) |=> ((oc_off_q & $past(retry_done)) == '0))
    else $error("tripped output not released after retry delay");

  AST_OC_HELD: assert property (
    (oc_off_q & stage_en_o[12:8]) == '0)
    else $error("tripped output driven while held off");

  AST_EC_CODE: assert property (
    ec_shown_q != 2'h3)
    else $error("comparator bits show the unused code");
endmodule

/* bench/host_model.sv */
/*
  Host side of the serial control link: one-cycle register strobes.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic                  clk_i,   // core clock
  input  wire logic [15:0]           rdata_i, // read data from the block
  output driver_diag_pkg::reg_req_t  req_o    // register access strobes
);
  // bus idle at time zero
  initial req_o = '0;

  //////////////////////////////////////////////////////////////////////////////
  // write: strobe for one edge, then scramble the released lines
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // read: data stands after the taking edge; reading a status word clears its flags but not the comparator bits
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hFFFF};
    #1 d = rdata_i;
  endtask
endmodule

/* bench/testbench.sv */
/*
  Self-checking bench for the diagnostic status and fine pwm block.
  Assumes host_model is compiled first and a 10 MHz core clock.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [12:0] ALL = 13'h1FFF;
  logic                      clk_i;
  logic                      reset_i;
  driver_diag_pkg::sense_t   sense;
  driver_diag_pkg::cfg_t     cfg;
  driver_diag_pkg::reg_req_t req;
  logic [15:0]               rdata;
  logic [12:0]               stage_en;
  logic                      g_uld;
  logic                      g_fault;
  logic                      pwm;
  int                        err_count;
  int                        cmp_count;
  int                        k, j, d, n, step;
  logic [15:0]               rd;
  logic [2:0]                m;
  logic [1:0]                prev;
  logic [1:0]                raw [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
  logic [1:0]                ecx [4] = '{2'b10, 2'b01, 2'b00, 2'b00};

  //////////////////////////////////////////////////////////////////////////////
  // 10 MHz core clock
  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  // short counts keep the run brief; expectations use the same figures
  driver_diag_status_regs #(
    .OC_RETRY_UNIT_CYC(8),
    .ULD_FILTER_CYC   (4),
    .EC_SETTLE_CYC    (16)
  ) driver_diag_status_regs_inst (
    .clk_i                         (clk_i),
    .reset_i                       (reset_i),
    .req_i                         (req),
    .sense_i                       (sense),
    .cfg_i                         (cfg),
    .reg_rdata_o                   (rdata),
    .stage_en_o                    (stage_en),
    .global_underload_o            (g_uld),
    .global_supply_or_overcurrent_o(g_fault),
    .out5_pwm_o                    (pwm)
  );

  host_model host_model_inst (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

  //////////////////////////////////////////////////////////////////////////////
  // status bit of half-bridge stage k in the underload word
  function automatic int ubit(int k);
    return (k < 6) ? 15 - k : 11 - k;
  endfunction

  task automatic tick(int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rd_chk(string nm, logic [7:0] a, logic [15:0] msk, logic [15:0] e);
    host_model_inst.reg_read(a, rd);
    check(nm, rd & msk, e);
  endtask

  // bounded wait on the pwm level; a hang counts as a mismatch
  task automatic wait_lvl(logic lvl);
    n = 0;
    while (pwm !== lvl) begin
      tick(1);
      #1 n++;
      if (n > 60000) begin
        err_count++;
        conclude();
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    cmp_count = 0;
    reset_i = 1'b1;
    sense = '0;
    cfg = '0;
    void'($urandom(32'hBBC7461E));
    tick(12);
    reset_i <= 1'b0;
    // reset values, read-only status, unused bits, unmapped address
    host_model_inst.reg_write(8'h11, 16'hFFFF);
    rd_chk("uld_reset", 8'h11, 16'hFFFF, 16'h0000);
    rd_chk("flt_reset", 8'h12, 16'hFFFF, 16'h0000);
    rd_chk("pwm_reset", 8'h13, 16'hFFFF, 16'h0000);
    rd_chk("unmapped", 8'h20, 16'hFFFF, 16'h0000);
    d = $urandom;
    host_model_inst.reg_write(8'h13, d[15:0]);
    rd_chk("pwm_rw", 8'h13, 16'hFFFF, d[15:0] & 16'h83FF);
    // underload on a random stage with random masks; first two forced masked
    tick(1);
    sense.on_req <= ALL;
    for (int i = 0; i < 6; i++) begin
      k = (i < 2) ? i : $urandom_range(7, 0);
      m = (i < 2) ? 3'b011 : 3'($urandom_range(7, 0));
      tick(1);
      cfg.mask_underload_high1 <= m[0];
      cfg.mask_underload_low1 <= m[1];
      cfg.mask_underload_all <= m[2];
      sense.under[k] <= 1'b1;
      tick(12);
      #1 check("g_uld", g_uld, !m[2] && !(k == 0 && m[0]) && !(k == 1 && m[1]));
      tick(1);
      sense.under[k] <= 1'b0;
      rd_chk("uld_flag", 8'h11, 16'hFFFF, 16'h0001 << ubit(k));
      rd_chk("uld_clr", 8'h11, 16'hFFFF, 16'h0000);
      check("g_uld_clr", g_uld, 1'b0);
    end
    // overcurrent trip, with and without recovery, random output and delay
    for (int i = 0; i < 4; i++) begin
      j = $urandom_range(4, 0);
      d = $urandom_range(3, 0);
      tick(1);
      cfg.oc_recovery_en <= i[0];
      cfg.overcurrent_retry_delay <= d[1:0];
      tick(1);
      sense.oc[j] <= 1'b1;
      tick(1);
      sense.oc[j] <= 1'b0;
      tick(1);
      #1 check("oc_off", stage_en[8+j], 1'b0);
      check("oc_global", g_fault, 1'b1);
      n = 0;
      while (stage_en[8+j] !== 1'b1 && n < 200) begin
        tick(1);
        #1 n++;
      end
      if (i[0]) check("retry", (n + 1 >= (d + 1) * 8 - 2) && (n + 1 <= (d + 1) * 8 + 2), 1'b1);
      else check("held_off", n, 200);
      rd_chk("oc_flag", 8'h12, 16'hFFF0, 16'h0001 << (15 - 2 * j));
      tick(3);
      #1 check("oc_back", stage_en[8+j], 1'b1);
    end
    // supply faults: undervoltage and overvoltage, auto and latched
    for (int i = 0; i < 4; i++) begin
      tick(1);
      cfg.supply_fault_latch_mode <= i[1];
      tick(1);
      if (i[0]) sense.ov <= 1'b1;
      else sense.uv <= 1'b1;
      tick(2);
      #1 check("sup_off", stage_en, 13'h0000);
      tick(1);
      sense.ov <= 1'b0;
      sense.uv <= 1'b0;
      tick(4);
      #1 check("sup_rel", stage_en, i[1] ? 13'h0000 : ALL);
      rd_chk("sup_flag", 8'h12, 16'h000C, i[0] ? 16'h0004 : 16'h0008);
      tick(3);
      #1 check("sup_back", stage_en, ALL);
    end
    // comparator status through every raw combination
    tick(1);
    cfg.ec_mode <= 1'b1;
    prev = 2'b00;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      {sense.ec_below, sense.ec_above} <= raw[i];
      tick(8);
      rd_chk("ec_early", 8'h12, 16'h0003, {14'h0000, prev});
      tick(30);
      rd_chk("ec_state", 8'h12, 16'h0003, {14'h0000, ecx[i]});
      check("ec_global", g_fault, 1'b0);
      prev = ecx[i];
    end
    // fine pwm high time at both frequencies
    tick(1);
    cfg.internal_pwm_select <= 1'b1;
    cfg.fine_duty_enable <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      d = $urandom_range(15, 0);
      step = f ? driver_diag_pkg::PWM_STEP_HI : driver_diag_pkg::PWM_STEP_LO;
      host_model_inst.reg_write(8'h13, {f[0], 5'h00, d[9:0]});
      // park the generator so a fresh period starts at once, not a full period later
      cfg.internal_pwm_select <= 1'b0;
      tick(2);
      #1 check("pwm_parked", pwm, 1'b0);
      tick(1);
      cfg.internal_pwm_select <= 1'b1;
      wait_lvl(1'b1);
      n = 0;
      while (pwm === 1'b1 && n < 2000) begin
        tick(1);
        #1 n++;
      end
      check("pwm_high", n, (d + 1) * step);
    end
    conclude();
  end
endmodule
